/* File: common/dsamc_pkg.sv */
// constants for the dual converter mode and configuration block
// assumes one system clock and a byte-wide register port
package dsamc_pkg;
   localparam logic [7:0] MODE_SELECT_ADDR   = 8'hBB;
   localparam logic [7:0] CONFIG_ADDR        = 8'hBC;
   localparam logic [7:0] RES0_HIGH_ADDR     = 8'hBD;
   localparam logic [7:0] RES0_LOW_ADDR      = 8'hBE;
   localparam logic [7:0] RES1_HIGH_ADDR     = 8'hBF;
   localparam logic [7:0] RES1_LOW_ADDR      = 8'hC0;
   localparam logic [7:0] MODE_SELECT_RESET  = 8'h00;
   localparam logic [7:0] CONFIG_RESET       = 8'hF0;
   localparam int         DIFF_BIT           = 6;
   localparam int         DIV_LSB            = 4;
   localparam int         SCAL_BIT           = 3;
   localparam int         GCAL_BIT           = 2;
   localparam int         LCAL_BIT           = 1;
   localparam int         OCAL_BIT           = 0;
   localparam int         RESULT_BITS        = 16;
   localparam int         CLK_PERIOD_NS      = 100;
   localparam int         TRACK_MIN_NS       = 280;
   localparam int         TRACK_CYCLES       = (TRACK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         CAL_SAR_CLOCKS     = 32;
   localparam logic [7:0] READ_UNMAPPED      = 8'h00;
endpackage

/* File: rtl/dsamc_sar.sv */
// one successive-approximation sequencer: track, then sixteen bit steps
// assumes comparator input synchronous to the clock
module dsamc_sar
   import dsamc_pkg::*;
(
   input  wire logic                   clk,      // system clock
   input  wire logic                   rst,      // sync reset
   input  wire logic                   ce,       // clock enable
   input  wire logic                   start,    // begin track and convert
   input  wire logic [3:0]             divider,  // clocks per step minus one
   input  wire logic                   comp_in,  // comparator: input above trial
   output logic [RESULT_BITS-1:0]      trial,    // trial word to the dac
   output logic [RESULT_BITS-1:0]      result,   // finished word
   output logic                        busy,     // track or convert running
   output logic                        done      // pulse on completion
);
   typedef enum logic [1:0] {DSAMC_IDLE, DSAMC_TRACK, DSAMC_CONV} dsamc_sar_e;
   dsamc_sar_e      state;
   logic [3:0]      div_cnt;
   logic [3:0]      track_cnt;
   logic [4:0]      bit_idx;
   wire             step = (div_cnt == divider);
   wire [RESULT_BITS-1:0] bit_mask = RESULT_BITS'(1) << bit_idx[3:0];
   wire [RESULT_BITS-1:0] kept = comp_in ? trial : (trial & ~bit_mask);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state     <= DSAMC_IDLE;
         div_cnt   <= '0;
         track_cnt <= '0;
         bit_idx   <= '0;
         trial     <= '0;
         result    <= '0;
         busy      <= 1'b0;
         done      <= 1'b0;
      end
      else if (ce)
      begin
         done <= 1'b0;
         case (state)
            DSAMC_IDLE:
            if (start)
            begin
               state     <= DSAMC_TRACK;
               track_cnt <= '0;
               busy      <= 1'b1;
            end
            DSAMC_TRACK:
            begin
               // track time is fixed in system clocks, independent of divider
               if (track_cnt == 4'(TRACK_CYCLES - 1)) // R06
               begin
                  state   <= DSAMC_CONV;
                  bit_idx <= 5'(RESULT_BITS - 1);
                  div_cnt <= '0;
                  trial <= RESULT_BITS'(1) << (RESULT_BITS - 1);
               end
               else
                  track_cnt <= track_cnt + 4'h1;
            end
            DSAMC_CONV:
            begin
               div_cnt <= step ? 4'h0 : div_cnt + 4'h1; // R08
               if (step)
               begin
                  if (bit_idx == 5'h0) // R07
                  begin
                     result <= kept;
                     state  <= DSAMC_IDLE;
                     busy   <= 1'b0;
                     done   <= 1'b1;
                  end
                  else
                  begin
                     trial   <= kept | (bit_mask >> 1);
                     bit_idx <= bit_idx - 5'h1;
                  end
               end
            end
            default: state <= DSAMC_IDLE;
         endcase
      end
   end

   a_track_before_conv: assert property (@(posedge clk) disable iff (rst) // R06
      (ce && state == DSAMC_IDLE && start) |=> state == DSAMC_TRACK ##1
      (state == DSAMC_TRACK || !ce)[*2]) else $error("tracking too short");
endmodule

/* File: rtl/dsamc_top.sv */
// mode select, configuration and result placement for two converters
// assumes byte register port on the processor bus, sync inputs
//
// Overview of operation
// [R01] mode bit 6 clear gives two independent converters, set gives one differential.
// [R02] single-ended, each converter writes its own high and low result pair.
// [R03] differential, the primary pair holds the combined two's-complement result.
// [R04] differential, the secondary pair still holds its own single-ended word.
// [R05] software writes zero into the unused mode register bits.
// [R06] every conversion is preceded by at least 280 ns of tracking.
// [R07] each conversion produces a sixteen-bit word.
// [R08] each conversion clock lasts divider value plus one system clocks.
// [R09] a calibration bit written 1 starts only when idle, reads 1 while running.
module dsamc_top
   import dsamc_pkg::*;
(
   input  wire logic                   REF_CLK,     // system clock, 10 MHz
   input  wire logic                   RST,         // sync reset, high
   input  wire logic                   CE,          // clock enable
   input  wire logic [7:0]             ADDR,        // register address
   input  wire logic                   WR_EN,       // write strobe
   input  wire logic                   RD_EN,       // read strobe
   input  wire logic [7:0]             WDATA,       // write data
   input  wire logic                   START0,      // primary start pulse
   input  wire logic                   START1,      // secondary start pulse
   input  wire logic                   COMP0,       // primary comparator
   input  wire logic                   COMP1,       // secondary comparator
   output logic [7:0]                  RDATA,       // read data, registered
   output logic [RESULT_BITS-1:0]      TRIAL0,      // primary trial word
   output logic [RESULT_BITS-1:0]      TRIAL1,      // secondary trial word
   output logic                        BUSY0,       // primary busy
   output logic                        BUSY1,       // secondary busy
   output logic                        DIFF_MODE,   // differential mode active
   output logic                        CAL_SOURCE   // external calibration source
);
   logic [7:0]              mode_reg;
   logic [7:0]              cfg_reg;
   logic [RESULT_BITS-1:0]  res0;
   logic [RESULT_BITS-1:0]  res1;
   logic [5:0]              cal_cnt;
   logic [RESULT_BITS-1:0]  trial0_w;
   logic [RESULT_BITS-1:0]  trial1_w;
   logic [RESULT_BITS-1:0]  word0;
   logic [RESULT_BITS-1:0]  word1;
   logic                    busy0_w;
   logic                    busy1_w;
   logic                    done0;
   logic                    done1;

   wire diff = mode_reg[DIFF_BIT];
   wire wr_mode = WR_EN && ADDR == MODE_SELECT_ADDR;
   wire wr_cfg  = WR_EN && ADDR == CONFIG_ADDR;
   wire [2:0] cal_run = cfg_reg[GCAL_BIT:OCAL_BIT];
   wire idle = !busy0_w && !busy1_w && cal_run == 3'b000;
   // in differential mode the secondary follows the primary start
   wire start1 = diff ? START0 : START1; // R01
   wire start0 = START0 && cal_run == 3'b000;
   wire cal_end = cal_run != 3'b000 && cal_cnt == 6'(CAL_SAR_CLOCKS - 1);
   // combined word: difference of the two unsigned halves, halved to fit
   wire [RESULT_BITS:0] diff_full = {1'b0, word0} - {1'b0, word1};
   wire [RESULT_BITS-1:0] diff_word = diff_full[RESULT_BITS:1];

   dsamc_sar u_sar0 (
      .clk     (REF_CLK),
      .rst     (RST),
      .ce      (CE),
      .start   (start0),
      .divider (cfg_reg[7:DIV_LSB]),
      .comp_in (COMP0),
      .trial   (trial0_w),
      .result  (word0),
      .busy    (busy0_w),
      .done    (done0)
   );
   dsamc_sar u_sar1 (
      .clk     (REF_CLK),
      .rst     (RST),
      .ce      (CE),
      .start   (start1 && cal_run == 3'b000),
      .divider (cfg_reg[7:DIV_LSB]),
      .comp_in (COMP1),
      .trial   (trial1_w),
      .result  (word1),
      .busy    (busy1_w),
      .done    (done1)
   );

   function automatic logic [7:0] read_mux(input logic [7:0] a);
      case (a)
         MODE_SELECT_ADDR: read_mux = mode_reg;
         CONFIG_ADDR:      read_mux = cfg_reg;
         RES0_HIGH_ADDR:   read_mux = res0[15:8];
         RES0_LOW_ADDR:    read_mux = res0[7:0];
         RES1_HIGH_ADDR:   read_mux = res1[15:8];
         RES1_LOW_ADDR:    read_mux = res1[7:0];
         default:          read_mux = READ_UNMAPPED;
      endcase
   endfunction

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         mode_reg   <= MODE_SELECT_RESET;
         cfg_reg    <= CONFIG_RESET;
         cal_cnt    <= '0;
         res0       <= '0;
         res1       <= '0;
         RDATA      <= '0;
         TRIAL0     <= '0;
         TRIAL1     <= '0;
         BUSY0      <= 1'b0;
         BUSY1      <= 1'b0;
         DIFF_MODE  <= 1'b0;
         CAL_SOURCE <= 1'b0;
      end
      else if (CE)
      begin
         // unused mode bits are not stored, so stray ones read back as zero
         if (wr_mode)
            mode_reg <= {1'b0, WDATA[DIFF_BIT], 6'h00}; // R01 R05
         if (wr_cfg)
         begin
            cfg_reg[7:SCAL_BIT] <= WDATA[7:SCAL_BIT];
            // a write of 1 only starts when idle; 0 never aborts
            if (idle)
               cfg_reg[GCAL_BIT:OCAL_BIT] <= WDATA[GCAL_BIT:OCAL_BIT]; // R09
         end
         // end of a run clears even when a refused write lands on the same edge
         if (cal_end)
            cfg_reg[GCAL_BIT:OCAL_BIT] <= 3'b000; // R09
         cal_cnt <= (cal_run != 3'b000 && !cal_end) ? cal_cnt + 6'h1 : 6'h0;
         if (done0)
            res0 <= diff ? diff_word : word0; // R02 R03
         if (done1)
            res1 <= word1; // R02 R04
         RDATA      <= RD_EN ? read_mux(ADDR) : 8'h00;
         TRIAL0     <= trial0_w;
         TRIAL1     <= trial1_w;
         BUSY0      <= busy0_w || cal_run != 3'b000;
         BUSY1      <= busy1_w;
         DIFF_MODE  <= diff;
         CAL_SOURCE <= cfg_reg[SCAL_BIT];
      end
   end

   a_mode_unused_zero: assert property (@(posedge REF_CLK) disable iff (RST) // R05
      mode_reg[7] == 1'b0 && mode_reg[5:0] == 6'h00) else $error("mode reserved bits set");
   a_diff_result: assert property (@(posedge REF_CLK) disable iff (RST) // R03
      (CE && done0 && diff && !RST) |=> res0 == $past(diff_word)) else $error("diff result");
   a_single_result: assert property (@(posedge REF_CLK) disable iff (RST) // R02
      (CE && done0 && !diff) |=> res0 == $past(word0)) else $error("single result");
   a_sec_result: assert property (@(posedge REF_CLK) disable iff (RST) // R04
      (CE && done1) |=> res1 == $past(word1)) else $error("secondary result");
   a_cal_busy_start: assert property (@(posedge REF_CLK) disable iff (RST) // R09
      (CE && wr_cfg && !idle) |=>
      cfg_reg[2:0] == ($past(cal_end) ? 3'b000 : $past(cfg_reg[2:0])))
      else $error("cal started while busy");
   a_diff_follow: assert property (@(posedge REF_CLK) disable iff (RST) // R01
      (CE && diff && START0 && !busy0_w && !busy1_w && cal_run == 3'b000) |=> busy1_w)
      else $error("secondary not slaved");
   a_mode_write: assert property (@(posedge REF_CLK) disable iff (RST) // R01
      (CE && wr_mode) |=> diff == $past(WDATA[DIFF_BIT])) else $error("mode write lost");
   a_conv_length: assert property (@(posedge REF_CLK) disable iff (RST) // R08
      (CE && done0) |-> $past(busy0_w, 2)) else $error("conversion too short");

   a_cal_clear_end: assert property (@(posedge REF_CLK) disable iff (RST) // R09
      (CE && cal_end) |=> cal_run == 3'b000)
      else $error("calibration not cleared");

   a_cal_busy_flag: assert property (@(posedge REF_CLK) disable iff (RST) // R09
      (CE && cal_run != 3'b000) |=> BUSY0)
      else $error("busy low during calibration");

   a_cal_count_bound: assert property (@(posedge REF_CLK) disable iff (RST) // R09
      cal_cnt <= 6'(CAL_SAR_CLOCKS - 1))
      else $error("calibration counter overran");

   a_cal_blocks_start: assert property (@(posedge REF_CLK) disable iff (RST) // R09
      (CE && cal_run != 3'b000 && !busy0_w) |=> !busy0_w)
      else $error("conversion started during calibration");

   a_cal_zero_write: assert property (@(posedge REF_CLK) disable iff (RST) // R09
      (CE && wr_cfg && WDATA[GCAL_BIT:OCAL_BIT] == 3'b000 && !cal_end) |=> cal_run == $past(cal_run))
      else $error("zero write changed calibration");

   a_cal_idle_start: assert property (@(posedge REF_CLK) disable iff (RST) // R09
      (CE && wr_cfg && idle) |=> cal_run == $past(WDATA[GCAL_BIT:OCAL_BIT]))
      else $error("idle calibration write lost");

   a_divider_write: assert property (@(posedge REF_CLK) disable iff (RST) // R08
      (CE && wr_cfg) |=> cfg_reg[7:DIV_LSB] == $past(WDATA[7:DIV_LSB]))
      else $error("divider write lost");

   a_sec_own_start: assert property (@(posedge REF_CLK) disable iff (RST) // R01
      (CE && !diff && !START1 && !busy1_w) |=> !busy1_w)
      else $error("secondary started without its own start");

   a_mode_output: assert property (@(posedge REF_CLK) disable iff (RST) // R01
      CE |=> DIFF_MODE == $past(diff))
      else $error("mode output stale");

   a_res0_hold: assert property (@(posedge REF_CLK) disable iff (RST) // R02
      (CE && !done0) |=> res0 == $past(res0))
      else $error("primary result changed without completion");

   a_res1_hold: assert property (@(posedge REF_CLK) disable iff (RST) // R04
      (CE && !done1) |=> res1 == $past(res1))
      else $error("secondary result changed without completion");

   a_read_res0_high: assert property (@(posedge REF_CLK) disable iff (RST) // R03
      (CE && RD_EN && ADDR == RES0_HIGH_ADDR) |=> RDATA == $past(res0[15:8]))
      else $error("primary high byte read wrong");

   a_read_res1_low: assert property (@(posedge REF_CLK) disable iff (RST) // R04
      (CE && RD_EN && ADDR == RES1_LOW_ADDR) |=> RDATA == $past(res1[7:0]))
      else $error("secondary low byte read wrong");

   a_read_mode: assert property (@(posedge REF_CLK) disable iff (RST) // R01
      (CE && RD_EN && ADDR == MODE_SELECT_ADDR) |=> RDATA == $past(mode_reg))
      else $error("mode register read wrong");

   a_sec_busy_out: assert property (@(posedge REF_CLK) disable iff (RST) // R04
      CE |=> BUSY1 == $past(busy1_w))
      else $error("secondary busy output stale");
endmodule

/* File: tb/test_dual_sar_adc_mode_config.sv */
// self-checking bench for the dual converter mode and configuration block
// assumes the register port, start/comparator pins, reset and clock enable are the only stimulus
module test_dual_sar_adc_mode_config
   import dsamc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic                   ref_clk, rst, ce, wr_en, rd_en, start0, start1, comp0, comp1;
   logic [7:0]             addr, wdata, rdata, m;
   logic [RESULT_BITS-1:0] trial0, trial1;
   logic                   busy0, busy1, diff_mode, cal_source;
   int                     fail_count = 0;
   int                     total_checks = 0;
   int                     cycles = 0;
   int                     n0, n1, n2, n3;

   dsamc_top dsamc_top_i (.REF_CLK(ref_clk), .RST(rst), .CE(ce), .ADDR(addr), .WR_EN(wr_en),
      .RD_EN(rd_en), .WDATA(wdata), .START0(start0), .START1(start1), .COMP0(comp0),
      .COMP1(comp1), .RDATA(rdata), .TRIAL0(trial0), .TRIAL1(trial1), .BUSY0(busy0),
      .BUSY1(busy1), .DIFF_MODE(diff_mode), .CAL_SOURCE(cal_source));

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // a hung conversion or calibration ends here
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         complete_run();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, e});
   endtask

   // counts busy cycles of both converters; waits on both busy flags, bounded
   task automatic conv(input logic c0, input logic c1, input logic s1, output int n,
      output int m);
      int k;
      n = 0;
      m = 0;
      @(posedge ref_clk);
      comp0 <= c0;
      comp1 <= c1;
      start0 <= 1'b1;
      start1 <= s1;
      @(posedge ref_clk);
      start0 <= 1'b0;
      start1 <= 1'b0;
      #1;
      for (k = 0; k < 600 && (k < 3 || busy0 === 1'b1 || busy1 === 1'b1); k++)
      begin
         n += (busy0 === 1'b1);
         m += (busy1 === 1'b1);
         @(posedge ref_clk);
         #1;
      end
      chk(16'(k < 600), 16'h0001);
      repeat (2) @(posedge ref_clk);
   endtask

   initial
   begin
      {rst, ce, addr, wdata, wr_en, rd_en, start0, start1, comp0, comp1} = {2'b11, 22'h0};
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      rchk(MODE_SELECT_ADDR, MODE_SELECT_RESET);
      rchk(CONFIG_ADDR, CONFIG_RESET);
      rchk(8'h55, READ_UNMAPPED);
      wr(MODE_SELECT_ADDR, 8'h40);
      rchk(MODE_SELECT_ADDR, 8'h40);
      chk({15'h0, diff_mode}, 16'h0001);
      wr(MODE_SELECT_ADDR, 8'h00);
      wr(CONFIG_ADDR, 8'h00);
      conv(1'b1, 1'b0, 1'b1, n0, n1);
      chk({15'h0, diff_mode}, 16'h0000);
      chk(16'(n0), 16'(TRACK_CYCLES + RESULT_BITS));
      chk(16'(n1), 16'(TRACK_CYCLES + RESULT_BITS));
      chk(trial0, 16'hFFFF);
      chk(trial1, 16'h0001);
      rchk(RES0_HIGH_ADDR, 8'hFF);
      rchk(RES0_LOW_ADDR, 8'hFF);
      rchk(RES1_HIGH_ADDR, 8'h00);
      wr(CONFIG_ADDR, 8'h10);
      conv(1'b0, 1'b1, 1'b1, n1, n2);
      chk(16'(n1 - n0), 16'(RESULT_BITS));
      rchk(RES0_LOW_ADDR, 8'h00);
      rchk(RES1_LOW_ADDR, 8'hFF);
      // differential: (0x0000 - 0xFFFF) >>> 1 in seventeen bits gives 0x8000
      wr(MODE_SELECT_ADDR, 8'h40);
      // secondary start pin stays low: the secondary must follow the primary start
      conv(1'b0, 1'b1, 1'b0, n2, n3);
      chk(16'(n3), 16'(TRACK_CYCLES + 2 * RESULT_BITS));
      rchk(RES0_HIGH_ADDR, 8'h80);
      rchk(RES0_LOW_ADDR, 8'h00);
      rchk(RES1_HIGH_ADDR, 8'hFF);
      rchk(RES1_LOW_ADDR, 8'hFF);
      wr(MODE_SELECT_ADDR, 8'h00);
      for (int b = OCAL_BIT; b <= GCAL_BIT; b++)
      begin
         m = 8'h01 << b;
         wr(CONFIG_ADDR, 8'h08 | m);
         rchk(CONFIG_ADDR, 8'h08 | m);
         chk({14'h0, cal_source, busy0}, 16'h0003);
         wr(CONFIG_ADDR, 8'h08);
         rchk(CONFIG_ADDR, 8'h08 | m);
         repeat (CAL_SAR_CLOCKS) @(posedge ref_clk);
         rchk(CONFIG_ADDR, 8'h08);
      end
      // a calibration asked for mid-conversion is dropped, divider still lands
      @(posedge ref_clk);
      start0 <= 1'b1;
      @(posedge ref_clk);
      start0 <= 1'b0;
      wr(CONFIG_ADDR, 8'h14);
      rchk(CONFIG_ADDR, 8'h10);
      // clock enable low: the write is frozen out
      @(posedge ref_clk);
      ce <= 1'b0;
      wr(CONFIG_ADDR, 8'h00);
      ce <= 1'b1;
      rchk(CONFIG_ADDR, 8'h10);
      repeat (3 * RESULT_BITS) @(posedge ref_clk);
      complete_run();
   end
endmodule
